// File: hw/i2c_ctrl_pkg.sv
// Constants and types for the control-channel I2C configuration block
package i2c_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_HOST_CFG = 8'h05;
    localparam logic [7:0] ADDR_DESER = 8'h06;
    localparam logic [7:0] ADDR_PHYS = 8'h07;
    localparam logic [7:0] ADDR_ALIAS = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_DLY_LSB = 3;
    localparam int CFG_BLOCK_BIT = 2;
    localparam int CFG_FAST_BIT = 1;
    localparam int CFG_WD_OFF_BIT = 0;
    localparam int DESER_HOLD_BIT = 0;
    localparam int ADDR7_LSB = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] CFG_RST = 5'h00;
    localparam logic [6:0] DESER_ADDR_RST = 7'h00;
    localparam logic HOLD_RST = 1'b0;
    localparam logic [7:0] PHYS_RST = 8'h00;
    localparam logic [6:0] ALIAS_RST = 7'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SDA_DLY_BASE_NS = 200;
    localparam int SDA_DLY_STEP_NS = 40;
    localparam int SDA_DLY_BASE_CYC = (SDA_DLY_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SDA_DLY_STEP_CYC = (SDA_DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SDA_DLY_MAX_CYC = SDA_DLY_BASE_CYC + 3 * SDA_DLY_STEP_CYC;
    localparam int WD_FAST_US = 50;
    localparam int WD_FAST_CYC = WD_FAST_US * 1000 / CLK_PERIOD_NS;
    localparam int WD_SLOW_S = 1;
    localparam int WD_SLOW_CYC_DEF = WD_SLOW_S * 1000000000 / CLK_PERIOD_NS;
    localparam int CLR_HALF_NS = 5000;
    localparam int CLR_HALF_CYC = CLR_HALF_NS / CLK_PERIOD_NS;
    localparam int CLR_PULSES = 9;
    localparam int NUM_PORTS = 2;

    typedef enum logic [1:0] {WD_WATCH, WD_CLR_LOW, WD_CLR_HIGH} wd_state_t;

endpackage : i2c_ctrl_pkg

// File: hw/i2c_ctrl_channel_addr_map.sv
// Control-channel I2C configuration: SDA delay, write block, watchdog, address map
`timescale 1ns/1ps
module i2c_ctrl_channel_addr_map
    import i2c_ctrl_pkg::*;
#(
    parameter int unsigned WD_SLOW_CYC = WD_SLOW_CYC_DEF
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_remote_i,
    input wire logic second_port_select_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_wr_reject_o,
    input wire logic [NUM_PORTS-1:0] rx_lock_i,
    input wire logic [NUM_PORTS-1:0] cc_id_valid_i,
    input wire logic [6:0] cc_id_i,
    input wire logic txn_valid_i,
    input wire logic [7:0] txn_addr_i,
    output logic fwd_valid_o,
    output logic [7:0] fwd_addr_o,
    output logic fwd_port_o,
    output logic fwd_alias_o,
    output logic txn_miss_o,
    input wire logic sda_drv_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic scl_o,
    output logic scl_oe_o,
    output logic bus_free_o
);

    default clocking cb_sys @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    function automatic logic addr_match(input logic [6:0] cfg, input logic [6:0] a);
        return (cfg != 7'h00) && (cfg == a);
    endfunction : addr_match

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [4:0] cfg_q;
    logic [6:0] des_addr_q [NUM_PORTS];
    logic hold_q [NUM_PORTS];
    logic [7:0] phys_q [NUM_PORTS];
    logic [6:0] alias_q [NUM_PORTS];
    logic [7:0] rdata_q;
    logic reject_q;
    logic [1:0] sda_dly_code;
    logic block_remote_reg_writes;
    logic bus_watchdog_fast;
    logic wd_off;
    logic remote_blocked;
    logic wr_ok;
    logic sel;
    logic [7:0] rdata_d;

    assign sda_dly_code = cfg_q[CFG_DLY_LSB+1:CFG_DLY_LSB];
    assign block_remote_reg_writes = cfg_q[CFG_BLOCK_BIT];
    assign bus_watchdog_fast = cfg_q[CFG_FAST_BIT];
    assign wd_off = cfg_q[CFG_WD_OFF_BIT];
    assign sel = second_port_select_i;
    // Only register writes are gated; the forwarding path never looks at this bit
    assign remote_blocked = reg_wr_i && reg_remote_i && block_remote_reg_writes;
    assign wr_ok = reg_wr_i && !remote_blocked;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q <= CFG_RST;
            rdata_q <= 8'h00;
            reject_q <= 1'b0;
        end else begin
            if (wr_ok && reg_addr_i == ADDR_HOST_CFG) begin
                cfg_q <= reg_wdata_i[4:0];
            end
            rdata_q <= reg_rd_i ? rdata_d : rdata_q;
            reject_q <= remote_blocked;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic port_wr;
            logic sw_id_wr;
            logic auto_load;
            assign port_wr = wr_ok && (sel == 1'(p));
            assign sw_id_wr = port_wr && reg_addr_i == ADDR_DESER;
            // Software write wins over a same-cycle auto-load
            assign auto_load = cc_id_valid_i[p] && rx_lock_i[p] && !hold_q[p]
                && !sw_id_wr;
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    des_addr_q[p] <= DESER_ADDR_RST;
                    hold_q[p] <= HOLD_RST;
                    phys_q[p] <= PHYS_RST;
                    alias_q[p] <= ALIAS_RST;
                end else begin
                    if (sw_id_wr) begin
                        des_addr_q[p] <= reg_wdata_i[7:ADDR7_LSB];
                        hold_q[p] <= reg_wdata_i[DESER_HOLD_BIT];
                    end else if (auto_load) begin
                        des_addr_q[p] <= cc_id_i;
                    end
                    if (port_wr && reg_addr_i == ADDR_PHYS) begin
                        phys_q[p] <= reg_wdata_i;
                    end
                    if (port_wr && reg_addr_i == ADDR_ALIAS) begin
                        alias_q[p] <= reg_wdata_i[7:ADDR7_LSB];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr_i)
            ADDR_HOST_CFG: rdata_d = {3'h0, cfg_q};
            ADDR_DESER: rdata_d = {des_addr_q[sel], hold_q[sel]};
            ADDR_PHYS: rdata_d = phys_q[sel];
            ADDR_ALIAS: rdata_d = {alias_q[sel], 1'b0};
            default: rdata_d = 8'h00;
        endcase
    end

    assign reg_rdata_o = rdata_q;
    assign reg_wr_reject_o = reject_q;

    // ------------------------------------------------------------------
    // Address decode and remap
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0] des_hit;
    logic [NUM_PORTS-1:0] alias_hit;
    logic [7:0] fwd_addr_q;
    logic fwd_valid_q, fwd_port_q, fwd_alias_q, miss_q, any_hit;

    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_dec
            assign des_hit[p] = addr_match(des_addr_q[p], txn_addr_i[7:ADDR7_LSB]);
            assign alias_hit[p] = addr_match(alias_q[p], txn_addr_i[7:ADDR7_LSB]);
        end
    endgenerate
    assign any_hit = |des_hit || |alias_hit;

    // Deserializer match takes priority over an alias, port 0 over port 1
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fwd_valid_q <= 1'b0;
            fwd_addr_q <= 8'h00;
            fwd_port_q <= 1'b0;
            fwd_alias_q <= 1'b0;
            miss_q <= 1'b0;
        end else begin
            fwd_valid_q <= txn_valid_i && any_hit;
            miss_q <= txn_valid_i && !any_hit;
            if (txn_valid_i && |des_hit) begin
                fwd_addr_q <= txn_addr_i;
                fwd_port_q <= !des_hit[0];
                fwd_alias_q <= 1'b0;
            end else if (txn_valid_i && |alias_hit) begin
                fwd_port_q <= !alias_hit[0];
                fwd_addr_q <= {phys_q[!alias_hit[0]][7:ADDR7_LSB], txn_addr_i[0]};
                fwd_alias_q <= 1'b1;
            end
        end
    end

    assign fwd_valid_o = fwd_valid_q;
    assign fwd_addr_o = fwd_addr_q;
    assign fwd_port_o = fwd_port_q;
    assign fwd_alias_o = fwd_alias_q;
    assign txn_miss_o = miss_q;

    // ------------------------------------------------------------------
    // SDA output delay
    // ------------------------------------------------------------------
    // Fixed-depth tap line keeps the delay exact for every code
    logic [SDA_DLY_MAX_CYC-1:0] sda_sh_q;
    logic [2:0] sda_tap;
    assign sda_tap = 3'(SDA_DLY_BASE_CYC - 1) + {1'b0, sda_dly_code};

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_sh_q <= '0;
        end else begin
            sda_sh_q <= {sda_sh_q[SDA_DLY_MAX_CYC-2:0], sda_drv_i};
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_sh_q[sda_tap];

    // ------------------------------------------------------------------
    // Bus watchdog and bus clear
    // ------------------------------------------------------------------
    wd_state_t wd_state_q;
    logic [24:0] wd_cnt_q;
    logic [24:0] wd_limit;
    logic [7:0] half_cnt_q;
    logic [3:0] pulses_q;
    logic scl_prev_q, sda_prev_q, free_q;
    logic activity, expire, half_done;

    assign wd_limit = bus_watchdog_fast ? 25'(WD_FAST_CYC) : 25'(WD_SLOW_CYC);
    assign activity = (scl_i != scl_prev_q) || (sda_i != sda_prev_q);
    assign expire = (wd_state_q == WD_WATCH) && !wd_off && !activity
        && (wd_cnt_q == wd_limit - 25'd1);
    assign half_done = half_cnt_q == 8'(CLR_HALF_CYC - 1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_state_q <= WD_WATCH;
            wd_cnt_q <= '0;
            half_cnt_q <= '0;
            pulses_q <= '0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            free_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_i;
            sda_prev_q <= sda_i;
            free_q <= expire && sda_i;
            if (wd_off || activity || expire || wd_state_q != WD_WATCH) begin
                wd_cnt_q <= '0;
            end else begin
                wd_cnt_q <= wd_cnt_q + 25'd1;
            end
            half_cnt_q <= (wd_state_q == WD_WATCH || half_done) ? 8'h00 : half_cnt_q + 8'h01;
            unique case (wd_state_q)
                WD_WATCH: begin
                    pulses_q <= '0;
                    if (expire && !sda_i) begin
                        wd_state_q <= WD_CLR_LOW;
                    end
                end
                WD_CLR_LOW: begin
                    if (wd_off) begin
                        wd_state_q <= WD_WATCH;
                    end else if (half_done) begin
                        wd_state_q <= WD_CLR_HIGH;
                    end
                end
                WD_CLR_HIGH: begin
                    if (wd_off) begin
                        wd_state_q <= WD_WATCH;
                    end else if (half_done) begin
                        pulses_q <= pulses_q + 4'd1;
                        wd_state_q <= (pulses_q == 4'(CLR_PULSES - 1)) ? WD_WATCH : WD_CLR_LOW;
                    end
                end
                default: wd_state_q <= WD_WATCH;
            endcase
        end
    end

    assign scl_o = 1'b0;
    assign scl_oe_o = wd_state_q == WD_CLR_LOW;
    assign bus_free_o = free_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [3:0] up_cnt_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_cnt_q <= '0;
        end else if (up_cnt_q != 4'hf) begin
            up_cnt_q <= up_cnt_q + 4'd1;
        end
    end

    sequence s_clear_start;
        wd_state_q == WD_WATCH && expire && !sda_i;
    endsequence
    sequence s_first_low;
        scl_oe_o [*2];
    endsequence

    property p_sda_delay_min;
        (up_cnt_q == 4'hf && sda_dly_code == 2'd0) |-> sda_oe_o == $past(sda_drv_i, 5);
    endproperty
    a_sda_delay_min: assert property (p_sda_delay_min) else $error("sda delay code 0 wrong");
    property p_sda_delay_max;
        (up_cnt_q == 4'hf && sda_dly_code == 2'd3) |-> sda_oe_o == $past(sda_drv_i, 8);
    endproperty
    a_sda_delay_max: assert property (p_sda_delay_max) else $error("sda delay code 3 wrong");
    property p_remote_reject;
        (reg_wr_i && reg_remote_i && block_remote_reg_writes && reg_addr_i == ADDR_PHYS)
        |=> reg_wr_reject_o && $stable(phys_q[0]) && $stable(phys_q[1]);
    endproperty
    a_remote_reject: assert property (p_remote_reject) else $error("remote write not blocked");
    property p_remote_fwd;
        (txn_valid_i && any_hit) |=> fwd_valid_o;
    endproperty
    a_remote_fwd: assert property (p_remote_fwd) else $error("hit not forwarded");
    property p_wd_bound;
        wd_cnt_q < wd_limit;
    endproperty
    a_wd_bound: assert property (p_wd_bound) else $error("watchdog count past limit");
    property p_free;
        bus_free_o |-> $past(sda_i) && !$past(wd_off) && $past(wd_cnt_q) == $past(wd_limit) - 25'd1;
    endproperty
    a_free: assert property (p_free) else $error("bus free without timeout");
    property p_clear;
        s_clear_start ##1 !wd_off |-> s_first_low;
    endproperty
    a_clear: assert property (p_clear) else $error("bus clear did not start");
    property p_pulse_cap;
        pulses_q <= 4'(CLR_PULSES);
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("too many clear pulses");
    property p_wd_off;
        wd_off |=> !bus_free_o && !scl_oe_o;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog acted while off");
    property p_autoload;
        (g_port[0].auto_load) |=> des_addr_q[0] == $past(cc_id_i);
    endproperty
    a_autoload: assert property (p_autoload) else $error("auto-load missed");
    property p_hold;
        (hold_q[0] && !g_port[0].sw_id_wr) |=> $stable(des_addr_q[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("held address changed");
    property p_remap;
        (txn_valid_i && !(|des_hit) && alias_hit[0])
        |=> fwd_alias_o && fwd_addr_o == {$past(phys_q[0][7:1]), $past(txn_addr_i[0])};
    endproperty
    a_remap: assert property (p_remap) else $error("alias remap wrong");
    property p_alias_zero;
        (txn_valid_i && alias_q[0] == 7'h00 && alias_q[1] == 7'h00) |=> !fwd_alias_o || !fwd_valid_o;
    endproperty
    a_alias_zero: assert property (p_alias_zero) else $error("zero alias matched");
    property p_port_sel;
        (wr_ok && sel && reg_addr_i == ADDR_ALIAS) |=> $stable(alias_q[0]);
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("wrong port written");

endmodule : i2c_ctrl_channel_addr_map

// File: test/deser_link_model.sv
// Far-side model: pulled-up I2C wires and control-channel address delivery
`timescale 1ns/1ps
module deser_link_model (
    input wire logic sys_clk_i,
    input wire logic sda_oe_i,
    input wire logic scl_oe_i,
    input wire logic host_sda_low_i,
    output logic sda_o,
    output logic scl_o,
    output logic [1:0] rx_lock_o,
    output logic [1:0] cc_id_valid_o,
    output logic [6:0] cc_id_o
);
    // Open-drain wires, pull-ups win when nobody pulls low
    assign sda_o = !(sda_oe_i || host_sda_low_i);
    assign scl_o = !scl_oe_i;

    initial begin
        rx_lock_o = 2'b00;
        cc_id_valid_o = 2'b00;
        cc_id_o = 7'h55;
    end

    // Lock comes first, the address one cycle later; data goes stale after
    task automatic send_id(input int p, input logic [6:0] id);
        @(posedge sys_clk_i);
        #1;
        rx_lock_o[p] = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cc_id_o = id;
        cc_id_valid_o[p] = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cc_id_valid_o[p] = 1'b0;
        cc_id_o = ~id;
    endtask : send_id
endmodule : deser_link_model

// File: test/tb_i2c_ctrl_channel_addr_map.sv
// Self-checking bench for the control-channel I2C configuration block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_i2c_ctrl_channel_addr_map;
    import i2c_ctrl_pkg::*;
    logic sys_clk_i, reset_n_i, wr, rd, remote, psel, rej, tv, fv, fp, fal, miss, drv;
    logic scl, sda, sda_oe, scl_oe, free, host_low, sdo, sco;
    logic [7:0] addr, wdata, rdata, ta, fa;
    logic [1:0] lock, idv;
    logic [6:0] id;
    logic [4:0] cfg_m;
    logic [7:0] deser_m[2], phys_m[2], alias_m[2];
    logic [31:0] rnd;
    int mismatches, check_count;

    i2c_ctrl_channel_addr_map #(.WD_SLOW_CYC(2000)) i_i2c_ctrl_channel_addr_map (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_remote_i(remote), .second_port_select_i(psel),
        .reg_rdata_o(rdata), .reg_wr_reject_o(rej), .rx_lock_i(lock), .cc_id_valid_i(idv),
        .cc_id_i(id), .txn_valid_i(tv), .txn_addr_i(ta), .fwd_valid_o(fv), .fwd_addr_o(fa),
        .fwd_port_o(fp), .fwd_alias_o(fal), .txn_miss_o(miss), .sda_drv_i(drv), .scl_i(scl),
        .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe), .scl_o(sco), .scl_oe_o(scl_oe),
        .bus_free_o(free));
    deser_link_model i_deser_link_model (.sys_clk_i(sys_clk_i), .sda_oe_i(sda_oe),
        .scl_oe_i(scl_oe), .host_sda_low_i(host_low), .sda_o(sda), .scl_o(scl),
        .rx_lock_o(lock), .cc_id_valid_o(idv), .cc_id_o(id));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Returns {miss, alias, port, address byte}; deser beats alias, port 0 first
    function automatic logic [10:0] dec(logic [7:0] a);
        for (int p = 0; p < 2; p++) if (deser_m[p][7:1] != 0 && deser_m[p][7:1] == a[7:1])
            return {2'b00, p[0], a};
        for (int p = 0; p < 2; p++) if (alias_m[p][7:1] != 0 && alias_m[p][7:1] == a[7:1])
            return {2'b01, p[0], phys_m[p][7:1], a[0]};
        return {1'b1, 10'h000};
    endfunction : dec

    task automatic tick;
        @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic wr_reg(logic [7:0] a, logic [7:0] d, logic r, logic p);
        logic refused;
        refused = r && cfg_m[CFG_BLOCK_BIT];
        addr = a; wdata = d; remote = r; psel = p; wr = 1'b1;
        tick;
        wr = 1'b0;
        `CHK("reject", refused, rej)
        if (!refused) case (a)
            ADDR_HOST_CFG: cfg_m = d[4:0];
            ADDR_DESER: deser_m[p] = d;
            ADDR_PHYS: phys_m[p] = d;
            ADDR_ALIAS: alias_m[p] = d & 8'hfe;
            default: ;
        endcase
        tick;
    endtask : wr_reg

    task automatic rd_chk(logic [7:0] a, logic p);
        logic [7:0] e;
        e = a == ADDR_HOST_CFG ? {3'h0, cfg_m} : a == ADDR_DESER ? deser_m[p] :
            a == ADDR_PHYS ? phys_m[p] : a == ADDR_ALIAS ? alias_m[p] : 8'h00;
        addr = a; psel = p; rd = 1'b1;
        tick;
        rd = 1'b0;
        `CHK("rdata", e, rdata)
        tick;
    endtask : rd_chk

    task automatic txn(logic [7:0] a);
        logic [10:0] e;
        e = dec(a);
        ta = a; tv = 1'b1;
        tick;
        tv = 1'b0;
        `CHK("miss", e[10], miss)
        `CHK("fwd valid", !e[10], fv)
        if (!e[10]) `CHK("fwd", e[9:0], {fal, fp, fa})
        tick;
    endtask : txn

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #(40 * 30000);
        mismatches++;
        give_verdict;
    end

    initial begin
        int n, k, pulses, hi;
        logic prev;
        logic [7:0] a;
        static logic [7:0] corner[9] = '{8'h61, 8'h60, 8'h42, 8'h43, 8'h44, 8'h45, 8'h00, 8'h01,
            8'h30};
        reset_n_i = 0; wr = 0; rd = 0; remote = 0; psel = 0; tv = 0; ta = 0; drv = 0;
        addr = 0; wdata = 0; host_low = 0; rnd = 32'h472b; cfg_m = CFG_RST;
        for (int p = 0; p < 2; p++) begin
            deser_m[p] = 8'h00; phys_m[p] = PHYS_RST; alias_m[p] = 8'h00;
        end
        repeat (16) @(posedge sys_clk_i);
        #1 reset_n_i = 1;
        for (int p = 0; p < 2; p++) for (int r = 4; r < 10; r++) rd_chk(r[7:0], p[0]);
        // Random accesses incl. unmapped offsets and refused remote writes
        repeat (40) begin
            rnd = lfsr(rnd);
            a = 8'h04 + {5'h0, rnd[2:0]};
            wr_reg(a, rnd[15:8], rnd[17], rnd[16]);
            rd_chk(a, rnd[16]);
        end
        wr_reg(ADDR_HOST_CFG, 8'h05, 1'b0, 1'b0);
        wr_reg(ADDR_PHYS, 8'haa, 1'b1, 1'b0);
        wr_reg(ADDR_HOST_CFG, 8'h00, 1'b1, 1'b0);
        rd_chk(ADDR_PHYS, 1'b0);
        rd_chk(ADDR_HOST_CFG, 1'b0);
        // Address map, with remote register writes still blocked
        wr_reg(ADDR_DESER, 8'h61, 1'b0, 1'b0);
        wr_reg(ADDR_DESER, 8'h01, 1'b0, 1'b1);
        wr_reg(ADDR_ALIAS, 8'h42, 1'b0, 1'b0);
        wr_reg(ADDR_PHYS, 8'ha1, 1'b0, 1'b0);
        wr_reg(ADDR_ALIAS, 8'h44, 1'b0, 1'b1);
        wr_reg(ADDR_PHYS, 8'h62, 1'b0, 1'b1);
        foreach (corner[i]) txn(corner[i]);
        repeat (20) begin
            rnd = lfsr(rnd);
            txn(rnd[7:0]);
        end
        wr_reg(ADDR_ALIAS, 8'h00, 1'b0, 1'b0);
        txn(8'h42);
        txn(8'h00);
        wr_reg(ADDR_ALIAS, 8'h00, 1'b0, 1'b1);
        txn(8'h44);
        wr_reg(ADDR_HOST_CFG, 8'h01, 1'b0, 1'b0);
        // Auto-load of the deserializer address
        wr_reg(ADDR_DESER, 8'h00, 1'b0, 1'b0);
        i_deser_link_model.send_id(0, 7'h3a);
        deser_m[0] = {7'h3a, 1'b0};
        tick;
        rd_chk(ADDR_DESER, 1'b0);
        i_deser_link_model.send_id(1, 7'h2b);
        tick;
        rd_chk(ADDR_DESER, 1'b1);
        // SDA delay per code
        for (int c = 0; c < 4; c++) begin
            wr_reg(ADDR_HOST_CFG, {3'h0, c[1:0], 3'b001}, 1'b0, 1'b0);
            drv = 1'b1;
            n = 0;
            do begin tick; n++; end while (sda_oe !== 1'b1 && n < 20);
            `CHK("sda delay", 5 + c, n)
            drv = 1'b0;
            repeat (12) tick;
        end
        // Watchdog: fast and slow expiry with SDA high
        for (int s = 0; s < 2; s++) begin
            wr_reg(ADDR_HOST_CFG, s ? 8'h00 : 8'h02, 1'b0, 1'b0);
            host_low = 1'b1;
            tick;
            host_low = 1'b0;
            n = 0;
            while (free !== 1'b1 && n < 5000) begin tick; n++; end
            k = s ? 2000 : WD_FAST_CYC;
            `CHK("wd expiry", 1'b1, n >= k - 3 && n <= k + 3)
        end
        // Bus clear with SDA held low
        wr_reg(ADDR_HOST_CFG, 8'h02, 1'b0, 1'b0);
        host_low = 1'b1;
        n = 0;
        while (scl_oe !== 1'b1 && n < 2000) begin tick; n++; end
        pulses = 1; hi = 0; prev = 1'b1;
        for (k = 0; k < 2300; k++) begin
            tick;
            if (scl_oe === 1'b1 && !prev) pulses++;
            if (k < 200 && scl_oe === 1'b1) hi++;
            prev = scl_oe;
        end
        `CHK("clear pulses", 9, pulses)
        `CHK("clear high", CLR_HALF_CYC - 1, hi)
        `CHK("scl drive level", 1'b0, sco)
        `CHK("sda drive level", 1'b0, sdo)
        // Disabled watchdog stays quiet whatever SDA does
        wr_reg(ADDR_HOST_CFG, 8'h03, 1'b0, 1'b0);
        pulses = 0;
        for (k = 0; k < 3000; k++) begin
            tick;
            if (free === 1'b1 || scl_oe === 1'b1) pulses++;
            if (k == 1500) host_low = 1'b0;
        end
        `CHK("wd off", 0, pulses)
        give_verdict;
    end
endmodule : tb_i2c_ctrl_channel_addr_map
